// *** design/trace_pkg.sv ***
package trace_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;

  localparam logic [ADDR_W-1:0] CTRL_OFS        = 4'h0;
  localparam logic [ADDR_W-1:0] TCR_OFS         = 4'h2;
  localparam logic [ADDR_W-1:0] WINDOW_HIGH_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] WINDOW_LOW_OFS  = 4'h5;
  localparam logic [ADDR_W-1:0] COUNT_OFS       = 4'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ARM_BIT  = 7;
  localparam int CTRL_BRK_BIT  = 0;
  localparam int TCR_SRC_BIT   = 6;
  localparam int TCR_ALIGN_LSB = 4;

  // ----------------------------------------------------------------
  // Alignment encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] ALIGN_END   = 2'h0;
  localparam logic [1:0] ALIGN_MID   = 2'h1;
  localparam logic [1:0] ALIGN_BEGIN = 2'h2;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic             ARM_RESET    = 1'b0;
  localparam logic             BRK_RESET    = 1'b0;
  localparam logic             SRC_RESET    = 1'b0;
  localparam logic [1:0]       ALIGN_RESET  = ALIGN_END;
  localparam logic             LOCK_RESET   = 1'b1;
  localparam logic [DATA_W-1:0] ZERO_WORD    = 16'h0000;
  localparam logic [DATA_W-1:0] INVALID_WORD = 16'hFFFF;
  localparam int               MID_POST_LINES = 32;
  localparam int               TRACE_DEPTH    = 64;
  localparam int               TRACE_WIDTH    = 64;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PRE,
    ST_STORE,
    ST_WAIT_BEGIN,
    ST_POST
  } seq_state_t;

endpackage

// *** design/trace_ram.sv ***
`timescale 1ns/100ps

module trace_ram #(
  parameter  int WIDTH = 64,
  parameter  int DEPTH = 64,
  localparam int AW    = $clog2(DEPTH)
) (
  input  wire logic             core_clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  // ----------------------------------------------------------------
  // Storage, never reset
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule

// *** design/debug_trace_buffer_control.sv ***
`timescale 1ns/100ps

module debug_trace_buffer_control #(
  parameter int DEPTH = trace_pkg::TRACE_DEPTH,
  parameter int WIDTH = trace_pkg::TRACE_WIDTH
) (
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  input  wire logic [trace_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [trace_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic                         reg_word,
  output logic      [trace_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                         seq_first_state,
  input  wire logic                         seq_final_state,
  input  wire logic                         trace_valid,
  input  wire logic [WIDTH-1:0]             trace_data,
  input  wire logic                         background_debug_active,
  output logic                              armed,
  output logic                              breakpoint_req,
  output logic                              seq_to_idle
);
  import trace_pkg::*;

  // ----------------------------------------------------------------
  // Derived sizes
  // ----------------------------------------------------------------
  localparam int PTR_W   = $clog2(DEPTH);
  localparam int CNT_W   = PTR_W + 1;
  localparam int WORDS   = WIDTH / DATA_W;
  localparam int WSEL_W  = $clog2(WORDS);
  localparam logic [PTR_W-1:0]  PTR_ONE   = PTR_W'(1);
  localparam logic [CNT_W-1:0]  CNT_ONE   = CNT_W'(1);
  localparam logic [CNT_W-1:0]  CNT_FULL  = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0]  CNT_MID   = CNT_W'(MID_POST_LINES);
  localparam logic [WSEL_W-1:0] WSEL_ONE  = WSEL_W'(1);
  localparam logic [WSEL_W-1:0] WSEL_LAST = WSEL_W'(WORDS - 1);

  if (WIDTH % DATA_W != 0 || WORDS < 2 || (WORDS & (WORDS - 1)) != 0 ||
      DEPTH < MID_POST_LINES || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
    $error("debug_trace_buffer_control: unsupported WIDTH or DEPTH");
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic ctrl_wr;
  logic tcr_wr;
  logic arm_start;
  logic win_wr_ok;
  logic win_rd_ok;
  logic             armed_q;
  logic             brk_en_q;
  logic             src_q;
  logic [1:0]       align_q;
  logic             locked_q;
  seq_state_t       state_q;
  seq_state_t       state_d;
  logic             session_end;
  logic             store_en;
  logic             post_store;
  logic [CNT_W-1:0] post_cnt_q;
  logic [CNT_W-1:0] post_cnt_d;
  logic [CNT_W-1:0] post_target;
  logic [PTR_W-1:0] wr_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic [PTR_W-1:0] rd_line_q;
  logic [PTR_W-1:0] rd_line_d;
  logic [WSEL_W-1:0] rd_word_q;
  logic [WSEL_W-1:0] rd_word_d;
  logic [PTR_W-1:0] oldest;
  logic [WIDTH-1:0] ram_q;
  logic [DATA_W-1:0] rd_val;
  logic             brk_q;
  logic             idle_q;

  assign ctrl_wr   = reg_wr && reg_addr == CTRL_OFS;
  assign tcr_wr    = reg_wr && reg_addr == TCR_OFS;
  assign arm_start = ctrl_wr && reg_wdata[CTRL_ARM_BIT] && !armed_q;
  assign win_wr_ok = reg_wr && reg_word && reg_addr == WINDOW_HIGH_OFS &&
                     !armed_q;
  assign win_rd_ok = reg_rd && reg_word && reg_addr == WINDOW_HIGH_OFS &&
                     !armed_q && !locked_q;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      src_q   <= SRC_RESET;
      align_q <= ALIGN_RESET;
    end else if (tcr_wr) begin
      src_q   <= reg_wdata[TCR_SRC_BIT];
      align_q <= reg_wdata[TCR_ALIGN_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      armed_q  <= ARM_RESET;
      brk_en_q <= BRK_RESET;
    end else if (ctrl_wr) begin
      armed_q  <= reg_wdata[CTRL_ARM_BIT];
      brk_en_q <= reg_wdata[CTRL_BRK_BIT];
    end else if (session_end) begin
      armed_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      locked_q <= LOCK_RESET;
    end else if (arm_start) begin
      locked_q <= 1'b1;
    end else if (win_wr_ok) begin
      locked_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Session sequencing
  // ----------------------------------------------------------------
  assign store_en = src_q && trace_valid && !background_debug_active &&
                    (state_q == ST_STORE || state_q == ST_POST ||
                     (state_q == ST_WAIT_BEGIN && seq_final_state));
  assign post_store  = store_en &&
                       (state_q == ST_POST || state_q == ST_WAIT_BEGIN);
  assign post_target = (align_q == ALIGN_MID) ? CNT_MID : CNT_FULL;
  assign post_cnt_d  = (state_q == ST_POST ? post_cnt_q : '0) +
                       (post_store ? CNT_ONE : '0);

  always_comb begin
    state_d     = state_q;
    session_end = 1'b0;
    case (state_q)
      ST_PRE: begin
        if (seq_final_state) begin
          session_end = 1'b1;
        end else if (seq_first_state && src_q) begin
          state_d = ST_STORE;
        end
      end
      ST_STORE: begin
        if (seq_final_state) begin
          if (align_q == ALIGN_MID) begin
            state_d = ST_POST;
          end else begin
            session_end = 1'b1;
          end
        end
      end
      ST_WAIT_BEGIN: begin
        state_d = seq_final_state ? ST_POST : ST_WAIT_BEGIN;
      end
      ST_POST: begin
        session_end = post_cnt_d == post_target;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (session_end) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else if (ctrl_wr && !reg_wdata[CTRL_ARM_BIT]) begin
      state_q <= ST_IDLE;
    end else if (arm_start) begin
      state_q <= (src_q && align_q == ALIGN_BEGIN) ? ST_WAIT_BEGIN
                                                   : ST_PRE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      post_cnt_q <= '0;
      brk_q      <= 1'b0;
      idle_q     <= 1'b0;
    end else begin
      post_cnt_q <= post_cnt_d;
      brk_q      <= session_end && brk_en_q;
      idle_q     <= session_end;
    end
  end

  // ----------------------------------------------------------------
  // Store side, kept across reset
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (arm_start) begin
      wr_ptr_q <= '0;
      count_q  <= '0;
    end else if (store_en) begin
      wr_ptr_q <= wr_ptr_q + PTR_ONE;
      if (count_q < CNT_FULL) begin
        count_q <= count_q + CNT_ONE;
      end
    end
  end

  trace_ram #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_ram (
    .core_clk (core_clk),
    .wr_en    (store_en),
    .wr_addr  (wr_ptr_q),
    .wr_data  (trace_data),
    .rd_addr  (rd_line_d),
    .rd_data  (ram_q)
  );

  // ----------------------------------------------------------------
  // Read window
  // ----------------------------------------------------------------
  assign oldest = (count_q >= CNT_FULL) ? wr_ptr_q : '0;

  always_comb begin
    rd_line_d = rd_line_q;
    rd_word_d = rd_word_q;
    if (win_wr_ok) begin
      rd_line_d = oldest;
      rd_word_d = '0;
    end else if (win_rd_ok) begin
      rd_word_d = rd_word_q + WSEL_ONE;
      if (rd_word_q == WSEL_LAST) begin
        rd_line_d = rd_line_q + PTR_ONE;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_line_q <= '0;
      rd_word_q <= '0;
    end else begin
      rd_line_q <= rd_line_d;
      rd_word_q <= rd_word_d;
    end
  end

  always_comb begin
    rd_val = ZERO_WORD;
    case (reg_addr)
      CTRL_OFS: begin
        rd_val[CTRL_ARM_BIT] = armed_q;
        rd_val[CTRL_BRK_BIT] = brk_en_q;
      end
      TCR_OFS: begin
        rd_val[TCR_SRC_BIT]          = src_q;
        rd_val[TCR_ALIGN_LSB +: 2]   = align_q;
      end
      WINDOW_HIGH_OFS: begin
        if (!reg_word) begin
          rd_val = ZERO_WORD;
        end else if (armed_q || locked_q) begin
          rd_val = INVALID_WORD;
        end else begin
          rd_val = ram_q[rd_word_q*DATA_W +: DATA_W];
        end
      end
      WINDOW_LOW_OFS: rd_val = ZERO_WORD;
      COUNT_OFS: begin
        rd_val[CNT_W-1:0] = count_q;
      end
      default: begin
        rd_val = ZERO_WORD;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= ZERO_WORD;
    end else begin
      reg_rdata <= reg_rd ? rd_val : ZERO_WORD;
    end
  end

  assign armed          = armed_q;
  assign breakpoint_req = brk_q;
  assign seq_to_idle    = idle_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence win_word_read;
    reg_rd && reg_word && reg_addr == WINDOW_HIGH_OFS;
  endsequence
  sequence final_enters_post;
    state_q == ST_WAIT_BEGIN && seq_final_state && !ctrl_wr;
  endsequence

  chk_armed_read_invalid: assert property (
    win_word_read and armed_q |=> reg_rdata == INVALID_WORD &&
                                  $stable(rd_line_q) && $stable(rd_word_q))
    else $error("armed window read not invalid or pointer moved");
  chk_byte_read_zero: assert property (
    reg_rd && !reg_word && reg_addr == WINDOW_HIGH_OFS |=>
      reg_rdata == ZERO_WORD && $stable(rd_word_q))
    else $error("byte window read not zero");
  chk_line_advance: assert property (
    win_rd_ok && rd_word_q == WSEL_LAST |=>
      rd_line_q == $past(rd_line_q) + PTR_ONE && rd_word_q == '0)
    else $error("read pointer did not advance after last word");
  chk_count_step: assert property (
    store_en && !arm_start && count_q < CNT_FULL |=>
      count_q == $past(count_q) + CNT_ONE)
    else $error("stored-line counter did not step");
  chk_no_trace_bdm: assert property (
    background_debug_active |-> !store_en)
    else $error("store while background debug active");
  chk_nosrc_final: assert property (
    state_q == ST_PRE && seq_final_state && !src_q && !reg_wr |=>
      !armed_q && seq_to_idle && breakpoint_req == $past(brk_en_q)
      ##1 !seq_to_idle)
    else $error("final without tracing did not disarm");
  chk_end_align: assert property (
    state_q == ST_STORE && seq_final_state && align_q == ALIGN_END &&
    !reg_wr |=> !armed_q && state_q == ST_IDLE)
    else $error("end alignment did not stop at final");
  chk_begin_hold: assert property (
    state_q == ST_WAIT_BEGIN && !seq_final_state |=>
      $stable(count_q) && $stable(wr_ptr_q))
    else $error("begin alignment stored before trigger");
  chk_begin_enter: assert property (
    final_enters_post |=> state_q == ST_POST && armed_q)
    else $error("begin trigger did not start session");
  chk_post_bound: assert property (
    state_q == ST_POST |-> post_cnt_q < post_target)
    else $error("post-trigger count overran");
  chk_ptr_wrap: assert property (
    store_en && !arm_start && wr_ptr_q == PTR_W'(DEPTH - 1) |=>
      wr_ptr_q == '0)
    else $error("write pointer did not wrap");

endmodule

// *** dv/reg_host_model.sv ***
`timescale 1ns/100ps

module reg_host_model (
  input  wire logic                         core_clk,
  input  wire logic [trace_pkg::DATA_W-1:0] reg_rdata,
  output logic      [trace_pkg::ADDR_W-1:0] reg_addr,
  output logic      [trace_pkg::DATA_W-1:0] reg_wdata,
  output logic                              reg_wr,
  output logic                              reg_rd,
  output logic                              reg_word
);
  import trace_pkg::*;

  // ----------------------------------------------------------------
  // Idle bus
  // ----------------------------------------------------------------
  initial begin
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_word  = 1'b1;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Write; word write to window high unlocks the buffer while not armed
  task automatic wr_reg(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic w);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_word  <= w;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read; data taken in the cycle after the strobe
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic w,
                        output logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_word <= w;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

// *** dv/debug_trace_buffer_control_tb.sv ***
`timescale 1ns/100ps

module debug_trace_buffer_control_tb;
  import trace_pkg::*;

  logic              core_clk;
  logic              reset;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic              reg_word;
  logic [DATA_W-1:0] reg_rdata;
  logic              seq_first_state;
  logic              seq_final_state;
  logic              trace_valid;
  logic [63:0]       trace_data;
  logic              background_debug_active;
  logic              armed;
  logic              breakpoint_req;
  logic              seq_to_idle;
  logic [DATA_W-1:0] d;
  int                err_total;
  int                num_checks;
  int                cyc_cnt;
  int                nxt;
  int                s;

  reg_host_model host_u (
    .core_clk (core_clk),
    .reg_rdata(reg_rdata),
    .reg_addr (reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr   (reg_wr),
    .reg_rd   (reg_rd),
    .reg_word (reg_word)
  );

  debug_trace_buffer_control dut_u (
    .core_clk               (core_clk),
    .reset                  (reset),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_word               (reg_word),
    .reg_rdata              (reg_rdata),
    .seq_first_state        (seq_first_state),
    .seq_final_state        (seq_final_state),
    .trace_valid            (trace_valid),
    .trace_data             (trace_data),
    .background_debug_active(background_debug_active),
    .armed                  (armed),
    .breakpoint_req         (breakpoint_req),
    .seq_to_idle            (seq_to_idle)
  );

  // ----------------------------------------------------------------
  // Clock and timeout
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One trace cycle; line words count up from the tag
  task automatic cyc(input logic f1, input logic fn, input logic v,
                     input logic b);
    @(posedge core_clk);
    seq_first_state         <= f1;
    seq_final_state         <= fn;
    trace_valid             <= v;
    background_debug_active <= b;
    trace_data <= {16'(nxt + 3), 16'(nxt + 2), 16'(nxt + 1), 16'(nxt)};
    if (v) nxt += 4;
  endtask

  task automatic burst(input int n, input logic b);
    repeat (n) cyc(1'b0, 1'b0, 1'b1, b);
    cyc(1'b0, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic arm(input logic src, input logic [1:0] al, input logic bk);
    host_u.wr_reg(TCR_OFS, {9'h000, src, al, 4'h0}, 1'b1);
    host_u.wr_reg(CTRL_OFS, {8'h00, 1'b1, 6'h00, bk}, 1'b1);
  endtask

  task automatic end_chk(input logic bp);
    cyc(1'b0, 1'b0, 1'b0, 1'b0);
    #1;
    chk("armed", 16'h0000, {15'h0, armed});
    chk("to_idle", 16'h0001, {15'h0, seq_to_idle});
    chk("brk", {15'h0, bp}, {15'h0, breakpoint_req});
    @(posedge core_clk);
    #1;
    chk("to_idle", 16'h0000, {15'h0, seq_to_idle});
  endtask

  task automatic rd_cnt(input logic [6:0] exp);
    host_u.rd_reg(COUNT_OFS, 1'b1, d);
    chk("count", {9'h000, exp}, {9'h000, d[6:0]});
  endtask

  task automatic rd_win(input int first, input int n);
    host_u.wr_reg(WINDOW_HIGH_OFS, 16'h0000, 1'b1);
    for (int i = 0; i < n; i++) begin
      host_u.rd_reg(WINDOW_HIGH_OFS, 1'b1, d);
      chk("window", 16'(first + i), d);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_lock();
    chk("armed", 16'h0000, {15'h0, armed});
    host_u.rd_reg(WINDOW_HIGH_OFS, 1'b1, d);
    chk("locked", INVALID_WORD, d);
    host_u.rd_reg(4'hE, 1'b1, d);
    chk("unmapped", ZERO_WORD, d);
  endtask

  task automatic t_end();
    arm(1'b1, ALIGN_END, 1'b1);
    burst(2, 1'b0);
    cyc(1'b1, 1'b0, 1'b0, 1'b0);
    s = nxt;
    burst(5, 1'b0);
    host_u.rd_reg(WINDOW_HIGH_OFS, 1'b1, d);
    chk("armed_read", INVALID_WORD, d);
    cyc(1'b0, 1'b1, 1'b0, 1'b0);
    end_chk(1'b1);
    rd_cnt(7'd5);
    rd_win(s, 6);
    host_u.rd_reg(WINDOW_HIGH_OFS, 1'b0, d);
    chk("byte_read", ZERO_WORD, d);
    host_u.rd_reg(WINDOW_LOW_OFS, 1'b1, d);
    chk("misaligned", ZERO_WORD, d);
    host_u.rd_reg(WINDOW_HIGH_OFS, 1'b1, d);
    chk("window", 16'(s + 6), d);
  endtask

  task automatic t_nosrc();
    arm(1'b0, ALIGN_END, 1'b1);
    cyc(1'b1, 1'b0, 1'b0, 1'b0);
    burst(2, 1'b0);
    cyc(1'b0, 1'b1, 1'b0, 1'b0);
    end_chk(1'b1);
    rd_cnt(7'd0);
    arm(1'b0, ALIGN_END, 1'b0);
    cyc(1'b1, 1'b0, 1'b0, 1'b0);
    cyc(1'b0, 1'b1, 1'b0, 1'b0);
    end_chk(1'b0);
  endtask

  task automatic t_mid();
    arm(1'b1, ALIGN_MID, 1'b0);
    cyc(1'b1, 1'b0, 1'b0, 1'b0);
    s = nxt;
    burst(2, 1'b0);
    burst(2, 1'b1);
    burst(1, 1'b0);
    cyc(1'b0, 1'b1, 1'b0, 1'b0);
    burst(36, 1'b0);
    #1;
    chk("armed", 16'h0000, {15'h0, armed});
    rd_cnt(7'd35);
    rd_win(s, 8);
  endtask

  task automatic t_begin();
    arm(1'b1, ALIGN_BEGIN, 1'b1);
    cyc(1'b1, 1'b0, 1'b0, 1'b0);
    burst(3, 1'b0);
    s = nxt;
    cyc(1'b0, 1'b1, 1'b1, 1'b0);
    cyc(1'b0, 1'b0, 1'b0, 1'b0);
    #1;
    chk("brk", 16'h0000, {15'h0, breakpoint_req});
    chk("armed", 16'h0001, {15'h0, armed});
    burst(62, 1'b0);
    #1;
    chk("armed", 16'h0001, {15'h0, armed});
    cyc(1'b0, 1'b0, 1'b1, 1'b0);
    end_chk(1'b1);
    burst(4, 1'b0);
    rd_cnt(7'd64);
    rd_win(s, 4);
  endtask

  task automatic t_wrap_reset();
    arm(1'b1, ALIGN_END, 1'b0);
    cyc(1'b1, 1'b0, 1'b0, 1'b0);
    burst(70, 1'b0);
    s = nxt - 256;
    cyc(1'b0, 1'b1, 1'b0, 1'b0);
    end_chk(1'b0);
    rd_cnt(7'd64);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd_cnt(7'd64);
    rd_win(s, 4);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset                   = 1'b1;
    seq_first_state         = 1'b0;
    seq_final_state         = 1'b0;
    trace_valid             = 1'b0;
    trace_data              = '0;
    background_debug_active = 1'b0;
    err_total               = 0;
    num_checks              = 0;
    cyc_cnt                 = 0;
    nxt                     = 0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    t_reset_lock();
    t_end();
    t_nosrc();
    t_mid();
    t_begin();
    t_wrap_reset();
    tally_and_finish();
  end
endmodule
